//--- verilog/lmb_pkg.sv
// How it works
// - Four 4-bit mode fields, sticky settings
// - Pulsing bit gates active outputs at 5 kHz
// - Rate field picks blink and stretch times
// - First port rate governs all ports
// - Combine-disable bit per output, resets zero
`default_nettype none
package lmb_pkg;
  // Clock rate
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = 20;
  // Half period of the fastest blink, in microseconds
  localparam int BLINK_BASE_US = 25_000;
  localparam int TICK_CYCLES = BLINK_BASE_US * CLK_MHZ;
  // Dimming pulse train rate
  localparam int PWM_HZ = 5_000;
  localparam int PWM_CYCLES = CLK_HZ / PWM_HZ;
  // Register indices; byte address is port*0x80 + index*4
  localparam logic [4:0] IDX_MODE = 5'h1D;
  localparam logic [4:0] IDX_BEHAV = 5'h1E;
  localparam logic [4:0] IDX_DUTY = 5'h10;
  localparam logic [4:0] IDX_STAT = 5'h11;
  // Reset values and writable bits
  localparam logic [15:0] MODE_RST = 16'h8021;
  localparam logic [15:0] BEHAV_RST = 16'h0400;
  localparam logic [15:0] BEHAV_WMASK = 16'h1DEF;
  localparam logic [7:0] DUTY_RST = 8'h80;
  // Field positions in the behaviour register
  localparam int PULSE_BIT = 12;
  localparam int RATE_LSB = 10;
  localparam int PSEL_LSB = 5;
  localparam int CDIS_LSB = 0;
  // Indicator modes served by this block
  localparam logic [3:0] MODE_LINK_ACT = 4'h0;
  localparam logic [3:0] MODE_DUP_COL = 4'h1;
  localparam logic [3:0] MODE_ACT = 4'h2;
  localparam logic [3:0] MODE_COL = 4'h3;
  localparam logic [3:0] MODE_OFF = 4'hE;
  localparam logic [3:0] MODE_ON = 4'hF;
endpackage
`default_nettype wire

//--- verilog/lmb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lmb_top
  import lmb_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] link_up,
  input wire logic [3:0] activity,
  input wire logic [3:0] full_duplex,
  input wire logic [3:0] collision,
  output logic [3:0] indicator_output_zero,
  output logic [3:0] indicator_output_one,
  output logic [3:0] indicator_output_two,
  output logic [3:0] indicator_output_three
);

  // Prescaler must fit its 20-bit counter
  generate
    if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > 20'hFFFFF)
    begin : g_bad_tick
      $error("TICK_CYCLES_P out of range");
    end
  endgenerate

  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES_P - 1);
  localparam logic [11:0] PWM_LAST = 12'(PWM_CYCLES - 1);

  // Whole module state
  typedef struct packed {
    logic [3:0][15:0] mode;    // Mode select per port
    logic [3:0][15:0] behav;   // Behaviour per port
    logic [3:0][7:0] duty;     // Dimming duty per port
    logic [3:0][3:0] s1;       // First sync stage [kind][port]
    logic [3:0][3:0] s2;       // Second sync stage
    logic [19:0] pre;          // Blink tick prescaler
    logic [3:0] ticks;         // Blink tick counter
    logic [11:0] pwm;          // Dimming period counter
    logic [3:0][4:0] stretch;  // Activity stretch per port
    logic [3:0][3:0] ind;      // Indicators [port][output]
    logic dph;                 // Data phase pending
    logic dwr;                 // Pending phase is a write
    logic dmap;                // Pending address in range
    logic [1:0] dport;         // Pending port
    logic [4:0] didx;          // Pending register index
    logic [31:0] rdata;        // Read data
  } lmb_state_type;

  lmb_state_type r;
  lmb_state_type n;

  // Reset image
  function automatic lmb_state_type lmb_reset();
    lmb_state_type v;
    v = '0;
    for (int p = 0; p < 4; p++)
    begin
      v.mode[p] = MODE_RST;
      v.behav[p] = BEHAV_RST;
      v.duty[p] = DUTY_RST;
    end
    return v;
  endfunction

  // Register read view, taken from the next state so a
  // back-to-back write then read returns the new value
  function automatic logic [31:0] lmb_read(lmb_state_type v,
                                          logic [1:0] p,
                                          logic [4:0] idx);
    logic [31:0] d;
    d = '0;
    case (idx)
      IDX_MODE: d[15:0] = v.mode[p];
      IDX_BEHAV: d[15:0] = v.behav[p];
      IDX_DUTY: d[7:0] = v.duty[p];
      IDX_STAT: d[7:0] = {v.s2[3][p], v.s2[2][p], v.s2[1][p],
                          v.s2[0][p], v.ind[p]};
      default: d = '0;
    endcase
    return d;
  endfunction

  // Next-state logic
  always_comb
  begin
    logic [1:0] rate;
    logic blink;
    logic pwm_on;
    logic tick;
    logic lnk;
    logic act;
    logic dup;
    logic col;
    logic act_any;
    logic act_show;
    logic on;
    logic [3:0] m;
    lmb_state_type view;  // Read view of the state
    rate = '0;
    blink = 1'b0;
    pwm_on = 1'b0;
    tick = 1'b0;
    lnk = 1'b0;
    act = 1'b0;
    dup = 1'b0;
    col = 1'b0;
    act_any = 1'b0;
    act_show = 1'b0;
    on = 1'b0;
    m = '0;
    view = '0;
    n = r;

    // Pin inputs pass two flops before use
    n.s1[0] = link_up;
    n.s1[1] = activity;
    n.s1[2] = full_duplex;
    n.s1[3] = collision;
    n.s2 = r.s1;

    // Blink time base
    tick = (r.pre == TICK_LAST);
    n.pre = tick ? '0 : r.pre + 20'h00001;
    if (tick)
    begin
      n.ticks = r.ticks + 4'h1;
    end
    // Dimming period
    n.pwm = (r.pwm == PWM_LAST) ? '0 : r.pwm + 12'h001;

    rate = r.behav[0][RATE_LSB +: 2];
    blink = r.ticks[~rate];

    // Write in the data phase; unmapped writes vanish
    if (r.dph && r.dwr && r.dmap)
    begin
      case (r.didx)
        IDX_MODE: n.mode[r.dport] = hwdata[15:0];
        IDX_BEHAV: n.behav[r.dport] = hwdata[15:0] & BEHAV_WMASK;
        IDX_DUTY: n.duty[r.dport] = hwdata[7:0];
        default: n.dph = r.dph;
      endcase
    end

    // Address phase capture
    if (hready)
    begin
      n.dph = hsel && htrans[1];
      n.dwr = hwrite;
      n.dmap = (haddr[31:9] == '0);
      n.dport = haddr[8:7];
      n.didx = haddr[6:2];
    end

    for (int p = 0; p < 4; p++)
    begin
      lnk = r.s2[0][p];
      act = r.s2[1][p];
      dup = r.s2[2][p];
      col = r.s2[3][p];
      if (act)
      begin
        n.stretch[p] = 5'h02 << ~rate;
      end
      else if (tick && r.stretch[p] != '0)
      begin
        n.stretch[p] = r.stretch[p] - 5'h01;
      end
      // Dimming gate for this port
      pwm_on = (r.pwm < {r.duty[p], 4'h0});
      for (int k = 0; k < 4; k++)
      begin
        m = r.mode[p][4*k +: 4];
        if (r.behav[p][PSEL_LSB + k])
        begin
          act_any = act || (r.stretch[p] != '0);
          act_show = act_any;
        end
        else
        begin
          act_any = act;
          act_show = act && blink;
        end
        case (m)
          MODE_LINK_ACT: on = lnk && (r.behav[p][CDIS_LSB + k] ||
                                      !act_any || act_show);
          MODE_DUP_COL: on = dup || (!r.behav[p][CDIS_LSB + k] &&
                                     col && blink);
          MODE_ACT: on = act_show;
          MODE_COL: on = col && blink;
          MODE_ON: on = 1'b1;
          MODE_OFF: on = 1'b0;
          default: on = 1'b0;
        endcase
        n.ind[p][k] = on && (!r.behav[p][PULSE_BIT] || pwm_on);
      end
    end

    // Read data is ready by the data phase, zero wait.
    // Status takes the second sync stage only; the next
    // value of that stage is the raw first flop.
    view = n;
    view.s2 = r.s2;
    n.rdata = '0;
    if (hready && hsel && htrans[1] && !hwrite &&
        haddr[31:9] == '0)
    begin
      n.rdata = lmb_read(view, haddr[8:7], haddr[6:2]);
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= lmb_reset();
    end
    else
    begin
      r <= n;
    end
  end

  // Bus answers: never stall, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;

  // Indicator pins straight from flops
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_pins
      assign indicator_output_zero[p] = r.ind[p][0];
      assign indicator_output_one[p] = r.ind[p][1];
      assign indicator_output_two[p] = r.ind[p][2];
      assign indicator_output_three[p] = r.ind[p][3];
    end
  endgenerate

endmodule
`default_nettype wire

//--- tb/lmb_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lmb_monitor
  import lmb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] indicator_output_zero
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read request taken at this edge
  logic rd_req;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("stall or error response");
  property p_hi_zero;
    rd_req |=> hrdata[31:16] == 16'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  property p_mask;
    rd_req && haddr[6:2] == IDX_BEHAV |=> (hrdata[15:0] & ~BEHAV_WMASK) == 0;
  endproperty
  a_mask: assert property (p_mask) else $error("reserved bits set");
  property p_unmap;
    rd_req && haddr[31:9] != 0 |=> hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_quiet;
    !rd_req |=> hrdata == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside phase");
  property p_dark;
    $rose(hresetn) |-> indicator_output_zero == 4'h0;
  endproperty
  a_dark: assert property (p_dark) else $error("lamp lit after reset");
endmodule
bind lmb_top lmb_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .indicator_output_zero(indicator_output_zero));
`default_nettype wire

//--- tb/lmb_lamps.sv
`timescale 1ns/100ps
`default_nettype none
module lmb_lamps
(
  input wire logic hclk,
  input wire logic clr,
  input wire logic lamp,
  output logic [7:0] flips
);
  logic last;
  // Observer counts each change of lamp state
  always_ff @(posedge hclk)
  begin
    last <= lamp;
    flips <= clr ? 8'h0 : flips + 8'((lamp !== last) ? 1 : 0);
  end
endmodule
`default_nettype wire

//--- tb/lmb_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lmb_top_tb
  import lmb_pkg::*;
;
  localparam int TK = 20;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdp = 0, clr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rnd = 32'hF433;
  logic hreadyout, hresp;
  logic [3:0] link_up = 0, activity = 0, full_duplex = 0, collision = 0;
  logic [3:0] o0, o1, o2, o3;
  logic [7:0] fl0, fl1;
  logic [31:0] expq[$];
  int error_cnt = 0, checks = 0;
  always #25 hclk = ~hclk;
  lmb_top #(.TICK_CYCLES_P(TK)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_up(link_up), .activity(activity), .full_duplex(full_duplex),
    .collision(collision), .indicator_output_zero(o0),
    .indicator_output_one(o1), .indicator_output_two(o2),
    .indicator_output_three(o3));
  lmb_lamps l0 (.hclk(hclk), .clr(clr), .lamp(o0[0]), .flips(fl0));
  lmb_lamps l1 (.hclk(hclk), .clr(clr), .lamp(o0[1]), .flips(fl1));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] ad(input int p, input logic [4:0] i);
    return 32'(p) * 32'h80 + {25'h0, i, 2'b00};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One single transfer, held until hready is seen high.
  // Select stays up afterwards; IDLE alone marks no request,
  // so back-to-back calls never drive hsel twice in a step.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rdp <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdp <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // Watcher takes the oldest note when read data stands
  always @(posedge hclk)
    if (rdp === 1'b1 && hreadyout === 1'b1)
      cmp(hrdata, expq.pop_front());
  // Program port zero, settle, then count lamp changes
  task automatic blink(input logic [15:0] b, input int n, input int s);
    xfer(1'b1, ad(0, IDX_BEHAV), {16'h0, b});
    repeat (4) @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (640) @(posedge hclk);
    cmp(32'(fl0 + s >= n && fl0 <= n + s), 32'h1);
  endtask
  task automatic end_of_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #(50 * 20000);
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ad(0, IDX_MODE), {16'h0, MODE_RST});
    rd(ad(0, IDX_BEHAV), {16'h0, BEHAV_RST});
    for (int p = 0; p < 4; p++)
    begin
      rnd = xs(rnd);
      xfer(1'b1, ad(p, IDX_MODE), rnd);
      rd(ad(p, IDX_MODE), {16'h0, rnd[15:0]});
      xfer(1'b1, ad(p, IDX_BEHAV), rnd);
      rd(ad(p, IDX_BEHAV), {16'h0, rnd[15:0] & BEHAV_WMASK});
    end
    rd(32'h200, 32'h0);
    $display("register test done");
    xfer(1'b1, ad(0, IDX_MODE), 32'h0);
    xfer(1'b1, ad(1, IDX_MODE), 32'h0);
    xfer(1'b1, ad(1, IDX_BEHAV), 32'h0C00);
    link_up <= 4'h3;
    activity <= 4'h3;
    for (int c = 0; c < 4; c++)
    begin
      blink(16'(c << 10), 640 / (TK * (8 >> c)), 1);
      cmp({24'h0, fl1}, {24'h0, fl0});
    end
    blink(16'h0420, 0, 0);
    blink(16'h0401, 0, 0);
    xfer(1'b1, ad(0, IDX_DUTY), 32'h0);
    blink(16'h1400, 0, 0);
    cmp({31'h0, o0[0]}, 32'h0);
    // Full duty lets the pulse gate pass; every output checked
    xfer(1'b1, ad(0, IDX_DUTY), 32'hFF);
    rd(ad(0, IDX_DUTY), 32'hFF);
    xfer(1'b1, ad(0, IDX_BEHAV), 32'h1440);
    xfer(1'b1, ad(0, IDX_MODE),
         {16'h0, MODE_ON, MODE_DUP_COL, MODE_ACT, MODE_OFF});
    full_duplex <= 4'h1;
    repeat (4) @(posedge hclk);
    cmp({28'h0, o3[0], o2[0], o1[0], o0[0]}, 32'hE);
    rd(ad(0, IDX_STAT), 32'h7E);
    // Collision mode blinks at the port zero rate
    xfer(1'b1, ad(0, IDX_MODE), {28'h0, MODE_COL});
    collision <= 4'h1;
    blink(16'h0400, 8, 1);
    $display("lamp test done");
    end_of_test;
  end
endmodule
`default_nettype wire
